// >>> inc/ppm_pkg.sv
// Constants, register map and mode encoding for the port pin mode logic
package ppm_pkg;

    // Pin population: ports 0..2 have 8 pins, port 3 has 2
    localparam int PIN_COUNT = 26;
    localparam int PORT_W = 8;
    localparam int PORT_NUM = 4;
    localparam int VEC_W = PORT_W * PORT_NUM;
    localparam int REG_AW = 8;
    localparam int REG_DW = 8;

    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int GLITCH_REJECT_NS = 50;
    localparam int GLITCH_CYCLES =
        (GLITCH_REJECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STRONG_PU_CYCLES = 2;

    // Register map
    localparam logic [REG_AW-1:0] ADDR_LATCH_BASE = 8'h00;
    localparam logic [REG_AW-1:0] ADDR_MODE_A_BASE = 8'h04;
    localparam logic [REG_AW-1:0] ADDR_MODE_B_BASE = 8'h08;
    localparam logic [REG_AW-1:0] ADDR_ANALOG_DIS = 8'h0C;
    localparam logic [REG_AW-1:0] ADDR_USER_CFG = 8'h0D;
    localparam logic [1:0] SEL_LATCH = 2'h0;
    localparam logic [1:0] SEL_MODE_A = 2'h1;
    localparam logic [1:0] SEL_MODE_B = 2'h2;
    localparam logic [1:0] SEL_MISC = 2'h3;
    localparam logic [REG_AW-1:0] ADDR_PAGE_MASK = 8'hF0;
    localparam logic [VEC_W-1:0] BYTE_LANE = 32'h0000_00FF;

    // Implemented pins and pins with restricted modes
    localparam logic [VEC_W-1:0] IMPL_MASK = 32'h03FF_FFFF;
    localparam int I2C_CLK_IDX = 10;
    localparam int I2C_DAT_IDX = 11;
    localparam int RST_PIN_IDX = 13;
    localparam logic [VEC_W-1:0] FORCE_A_SET = 32'h0000_2C00;
    localparam logic [VEC_W-1:0] FORCE_B_CLR = 32'h0000_2000;

    // Reset values
    localparam logic [VEC_W-1:0] LATCH_RST = 32'h03FF_FFFF;
    localparam logic [VEC_W-1:0] MODE_A_RST = 32'h03FF_FFFF;
    localparam logic [VEC_W-1:0] MODE_B_RST = 32'h0000_0000;
    localparam logic [REG_DW-1:0] ANALOG_RST = 8'h00;

    // Analog input disable and user configuration fields
    localparam logic [REG_DW-1:0] ANALOG_USED_MASK = 8'h3E;
    localparam int RST_SEL_BIT = 6;

    // Pin mode, {mode bit a, mode bit b}
    typedef enum logic [1:0] {
        MODE_QUASI = 2'b00,
        MODE_PUSH_PULL = 2'b01,
        MODE_INPUT_ONLY = 2'b10,
        MODE_OPEN_DRAIN = 2'b11
    } ppm_mode_t;

endpackage

// >>> hdl/ppm_pin_cell.sv
// One port pin: input glitch filter and output driver selection
`timescale 1ns/1ps
`default_nettype none
module ppm_pin_cell #(
    parameter int FILTER_CYCLES = ppm_pkg::GLITCH_CYCLES,
    parameter int PULSE_CYCLES = ppm_pkg::STRONG_PU_CYCLES
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic pin_in,
    input wire logic latch,
    input wire ppm_pkg::ppm_mode_t mode,
    output logic level_q,
    output logic drive_out_q,
    output logic drive_oe_n_q,
    output logic weak_pu_q,
    output logic very_weak_pu_q
);
    import ppm_pkg::*;

    localparam int FCW = $clog2(FILTER_CYCLES + 1);
    localparam int PCW = $clog2(PULSE_CYCLES + 1);

    logic [FCW-1:0] flt_cnt_q;
    logic [PCW-1:0] pulse_cnt_q;
    logic latch_prev_q;
    logic latch_rise;
    logic pull_down;
    logic strong_up;

    // Level moves only after the pin differs for FILTER_CYCLES cycles
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            level_q <= 1'b0;
            flt_cnt_q <= '0;
        end else if (pin_in == level_q) begin
            flt_cnt_q <= '0;
        end else if (flt_cnt_q == FCW'(FILTER_CYCLES - 1)) begin
            level_q <= pin_in;
            flt_cnt_q <= '0;
        end else begin
            flt_cnt_q <= flt_cnt_q + FCW'(1);
        end
    end

    assign latch_rise = latch && !latch_prev_q;

    // Strong pull-up pulse after a 0 to 1 latch change in quasi mode
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            latch_prev_q <= 1'b1;
            pulse_cnt_q <= '0;
        end else begin
            latch_prev_q <= latch;
            if (mode == MODE_QUASI && latch_rise) begin
                pulse_cnt_q <= PCW'(PULSE_CYCLES - 1);
            end else if (pulse_cnt_q != '0) begin
                pulse_cnt_q <= pulse_cnt_q - PCW'(1);
            end
        end
    end

    // One pulldown path shared by every driving mode
    assign pull_down = !latch && (mode != MODE_INPUT_ONLY);

    always_comb begin
        strong_up = 1'b0;
        unique case (mode)
            MODE_QUASI: begin
                strong_up = latch && (latch_rise || pulse_cnt_q != '0);
            end
            MODE_PUSH_PULL: begin
                strong_up = latch;
            end
            MODE_INPUT_ONLY: begin
                strong_up = 1'b0;
            end
            MODE_OPEN_DRAIN: begin
                strong_up = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            drive_out_q <= 1'b0;
            drive_oe_n_q <= 1'b1;
            weak_pu_q <= 1'b0;
            very_weak_pu_q <= 1'b0;
        end else begin
            drive_out_q <= strong_up;
            drive_oe_n_q <= !(pull_down || strong_up);
            very_weak_pu_q <= (mode == MODE_QUASI) && latch;
            weak_pu_q <= (mode == MODE_QUASI) && latch && level_q;
        end
    end

endmodule
`default_nettype wire

// >>> hdl/ppm_port_pin_mode_logic.sv
// Port pin mode logic: registers, pin cells and reset pin handling
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ppm_port_pin_mode_logic #(
    parameter int FILTER_CYCLES = ppm_pkg::GLITCH_CYCLES,
    parameter int PULSE_CYCLES = ppm_pkg::STRONG_PU_CYCLES
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [ppm_pkg::REG_AW-1:0] addr,
    input wire logic [ppm_pkg::REG_DW-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [ppm_pkg::REG_DW-1:0] rdata_q,
    input wire logic [ppm_pkg::PIN_COUNT-1:0] pin_in,
    output logic [ppm_pkg::PIN_COUNT-1:0] pin_out,
    output logic [ppm_pkg::PIN_COUNT-1:0] pin_oe_n,
    output logic [ppm_pkg::PIN_COUNT-1:0] pin_weak_pu_en,
    output logic [ppm_pkg::PIN_COUNT-1:0] pin_very_weak_pu_en,
    output logic [ppm_pkg::PIN_COUNT-1:0] pin_level_q,
    input wire logic [ppm_pkg::REG_DW-1:0] user_config_byte_one,
    input wire logic power_on_active,
    output logic pin_reset_req_q
);
    import ppm_pkg::*;

    logic [VEC_W-1:0] latch_q;
    logic [VEC_W-1:0] mode_a_q;
    logic [VEC_W-1:0] mode_b_q;
    logic [REG_DW-1:0] analog_q;
    logic [VEC_W-1:0] lane_sel;
    logic [VEC_W-1:0] wr_word;
    logic [VEC_W-1:0] filt_w;
    logic [VEC_W-1:0] in_dis;
    logic [VEC_W-1:0] read_level;
    logic [REG_DW-1:0] rdata_d;
    logic [VEC_W-1:0] page_word;
    logic page_hit;
    logic reset_pin_as_input_select;
    logic [VEC_W-1:0] latch_d1_q;

    // Byte lane of the addressed port within the flat pin vectors
    assign lane_sel = BYTE_LANE << {addr[1:0], 3'b000};
    assign wr_word = {PORT_NUM{wdata}};
    assign page_hit = (addr & ADDR_PAGE_MASK) == ADDR_LATCH_BASE;

    // Output latches
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            latch_q <= LATCH_RST;
        end else if (wr_en && page_hit && addr[3:2] == SEL_LATCH) begin
            latch_q <= ((latch_q & ~lane_sel) | (wr_word & lane_sel))
                & IMPL_MASK;
        end
    end

    // Mode bit a; restricted pins keep bit a set
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mode_a_q <= MODE_A_RST;
        end else if (wr_en && page_hit && addr[3:2] == SEL_MODE_A) begin
            mode_a_q <= (((mode_a_q & ~lane_sel) | (wr_word & lane_sel))
                | FORCE_A_SET) & IMPL_MASK;
        end
    end

    // Mode bit b; the reset pin keeps bit b clear
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mode_b_q <= MODE_B_RST;
        end else if (wr_en && page_hit && addr[3:2] == SEL_MODE_B) begin
            mode_b_q <= ((mode_b_q & ~lane_sel) | (wr_word & lane_sel))
                & ~FORCE_B_CLR & IMPL_MASK;
        end
    end

    // Port 0 digital input disable
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            analog_q <= ANALOG_RST;
        end else if (wr_en && addr == ADDR_ANALOG_DIS) begin
            analog_q <= wdata;
        end
    end

    // Only bits 1 to 5 map onto port 0 pins 1 to 5
    assign in_dis = {{(VEC_W - REG_DW){1'b0}},
        analog_q & ANALOG_USED_MASK};
    assign read_level = filt_w & ~in_dis & IMPL_MASK;

    // Per-pin cells
    genvar i;
    generate
        for (i = 0; i < PIN_COUNT; i++) begin : g_pin
            ppm_mode_t pin_mode;
            assign pin_mode = ppm_mode_t'({mode_a_q[i], mode_b_q[i]});
            ppm_pin_cell #(
                .FILTER_CYCLES(FILTER_CYCLES),
                .PULSE_CYCLES(PULSE_CYCLES)
            ) u_cell (
                .clk_sys(clk_sys),
                .resetn(resetn),
                .pin_in(pin_in[i]),
                .latch(latch_q[i]),
                .mode(pin_mode),
                .level_q(filt_w[i]),
                .drive_out_q(pin_out[i]),
                .drive_oe_n_q(pin_oe_n[i]),
                .weak_pu_q(pin_weak_pu_en[i]),
                .very_weak_pu_q(pin_very_weak_pu_en[i])
            );
        end
    endgenerate
    assign filt_w[VEC_W-1:PIN_COUNT] = '0;

    // Levels handed to the core's own input functions
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pin_level_q <= '0;
        end else begin
            pin_level_q <= read_level[PIN_COUNT-1:0];
        end
    end

    // Reset pin: always a reset input while power-on runs
    assign reset_pin_as_input_select = user_config_byte_one[RST_SEL_BIT];
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pin_reset_req_q <= 1'b0;
        end else begin
            pin_reset_req_q <= (power_on_active
                || !reset_pin_as_input_select) && !filt_w[RST_PIN_IDX];
        end
    end

    // Register read mux; unmapped addresses read zero
    always_comb begin
        rdata_d = '0;
        page_word = '0;
        if (page_hit) begin
            unique case (addr[3:2])
                SEL_LATCH: page_word = read_level;
                SEL_MODE_A: page_word = mode_a_q;
                SEL_MODE_B: page_word = mode_b_q;
                SEL_MISC: page_word = '0;
            endcase
            rdata_d = REG_DW'((page_word & lane_sel)
                >> {addr[1:0], 3'b000});
            if (addr == ADDR_ANALOG_DIS) begin
                rdata_d = analog_q;
            end else if (addr == ADDR_USER_CFG) begin
                rdata_d = user_config_byte_one;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= '0;
        end else if (rd_en) begin
            rdata_q <= rdata_d;
        end
    end

    // Helper for the pulse checks below
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            latch_d1_q <= LATCH_RST;
        end else begin
            latch_d1_q <= latch_q;
        end
    end

    // Checks on every pin
    generate
        for (i = 0; i < PIN_COUNT; i++) begin : g_chk
            AST_OPEN_DRAIN: assert property (
                @(posedge clk_sys) disable iff (!resetn)
                (mode_a_q[i] && mode_b_q[i]) |=>
                    !pin_weak_pu_en[i] && !pin_very_weak_pu_en[i]
                    && !pin_out[i]
                    && (pin_oe_n[i] == $past(latch_q[i])))
                else $error("open drain pin drives high or misses low");

            AST_PUSH_PULL: assert property (
                @(posedge clk_sys) disable iff (!resetn)
                (!mode_a_q[i] && mode_b_q[i]) |=>
                    !pin_oe_n[i] && (pin_out[i] == $past(latch_q[i])))
                else $error("push-pull pin does not follow its latch");

            AST_SHARED_PULLDOWN: assert property (
                @(posedge clk_sys) disable iff (!resetn)
                (!latch_q[i] && !(mode_a_q[i] && !mode_b_q[i])) |=>
                    !pin_oe_n[i] && !pin_out[i])
                else $error("low latch not driven low by the pulldown");

            AST_INPUT_ONLY: assert property (
                @(posedge clk_sys) disable iff (!resetn)
                (mode_a_q[i] && !mode_b_q[i]) |=>
                    pin_oe_n[i] && !pin_weak_pu_en[i]
                    && !pin_very_weak_pu_en[i])
                else $error("input-only pin has a driver on");

            AST_FILTER: assert property (
                @(posedge clk_sys) disable iff (!resetn)
                $changed(filt_w[i]) |->
                    ($past(pin_in[i]) == filt_w[i])
                    && ($past(pin_in[i], 2) == filt_w[i]))
                else $error("filtered level took a short glitch");

            AST_VERY_WEAK: assert property (
                @(posedge clk_sys) disable iff (!resetn)
                (!mode_a_q[i] && !mode_b_q[i] && latch_q[i]) |=>
                    pin_very_weak_pu_en[i])
                else $error("quasi pin lacks its very weak pull-up");

            AST_WEAK_OFF: assert property (
                @(posedge clk_sys) disable iff (!resetn)
                (!mode_a_q[i] && !mode_b_q[i] && !filt_w[i]) |=>
                    !pin_weak_pu_en[i])
                else $error("weak pull-up on while pin is held low");

            AST_STRONG_ON: assert property (
                @(posedge clk_sys) disable iff (!resetn)
                (!mode_a_q[i] && !mode_b_q[i]
                    && latch_q[i] && !latch_d1_q[i]) ##1
                (!mode_a_q[i] && !mode_b_q[i] && latch_q[i]) |=>
                    !pin_oe_n[i] && pin_out[i] ##1 pin_oe_n[i])
                else $error("strong pull-up pulse is not two clocks");
        end
    endgenerate

    AST_ANALOG_MASK: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (rd_en && addr == ADDR_LATCH_BASE) |=>
            (rdata_q & $past(analog_q) & ANALOG_USED_MASK) == '0)
        else $error("disabled port 0 input did not read zero");

    AST_ANALOG_RESET: assert property (
        @(posedge clk_sys)
        !resetn |-> (analog_q == ANALOG_RST))
        else $error("analog disable not cleared by reset");

    AST_POWER_UP: assert property (
        @(posedge clk_sys)
        !resetn |-> (&pin_oe_n) && !(|pin_weak_pu_en)
            && !(|pin_very_weak_pu_en))
        else $error("pin drives during reset");

    AST_RESTRICTED: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        mode_a_q[RST_PIN_IDX] && !mode_b_q[RST_PIN_IDX]
            && mode_a_q[I2C_CLK_IDX] && mode_a_q[I2C_DAT_IDX])
        else $error("restricted pin left its allowed modes");

    AST_I2C_NO_HIGH: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        !pin_out[I2C_CLK_IDX] && !pin_out[I2C_DAT_IDX]
            && !pin_weak_pu_en[I2C_CLK_IDX]
            && !pin_weak_pu_en[I2C_DAT_IDX])
        else $error("shared I2C pin driven high");

    AST_POR_RESET_PIN: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (power_on_active && !filt_w[RST_PIN_IDX]) |=> pin_reset_req_q)
        else $error("reset pin ignored during power-on");

    AST_GP_RESET_PIN: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (!power_on_active && reset_pin_as_input_select) |=>
            !pin_reset_req_q)
        else $error("reset pin acting as reset in input use");

    AST_READ_LEVEL: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (rd_en && addr == ADDR_LATCH_BASE + 8'h01) |=>
            rdata_q == $past(read_level[15:8]))
        else $error("port read did not return the pin level");

endmodule
`default_nettype wire

// >>> tb/ppm_ext_circuit.sv
// Model of the circuitry outside the port pins
`timescale 1ns/1ps
`default_nettype none
module ppm_ext_circuit (
    input wire logic clk_sys,
    input wire logic [ppm_pkg::PIN_COUNT-1:0] pin_out,
    input wire logic [ppm_pkg::PIN_COUNT-1:0] pin_oe_n,
    input wire logic [ppm_pkg::PIN_COUNT-1:0] pin_weak_pu_en,
    input wire logic [ppm_pkg::PIN_COUNT-1:0] pin_very_weak_pu_en,
    input wire logic [ppm_pkg::PIN_COUNT-1:0] ext_en,
    input wire logic [ppm_pkg::PIN_COUNT-1:0] ext_val,
    output logic [ppm_pkg::PIN_COUNT-1:0] pin_in
);
    import ppm_pkg::*;
    logic float_q = 1'b0;
    // Undriven pads show a pattern that flips every cycle
    always @(posedge clk_sys) begin
        float_q <= ~float_q;
    end
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (ext_en[i]) begin
                // Outside drivers overpower any pull-up
                pin_in[i] = ext_val[i];
            end else if (!pin_oe_n[i]) begin
                pin_in[i] = pin_out[i];
            end else if (pin_weak_pu_en[i] || pin_very_weak_pu_en[i]) begin
                pin_in[i] = 1'b1;
            end else begin
                pin_in[i] = float_q ^ i[0];
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the port pin mode logic
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ppm_pkg::*;
    logic clk_sys, resetn, wr_en, rd_en, power_on_active, rd_prev;
    logic pin_reset_req_q;
    logic [REG_AW-1:0] addr;
    logic [REG_DW-1:0] wdata, rdata_q, user_config_byte_one;
    logic [PIN_COUNT-1:0] pin_in, pin_out, pin_oe_n, pin_weak_pu_en;
    logic [PIN_COUNT-1:0] pin_very_weak_pu_en, pin_level_q, ext_en, ext_val;
    logic [7:0] exp_q[$];
    logic [7:0] lat, av, pv, eo, eu, ep;
    int n_mismatch, samples_checked, seed;

    ppm_port_pin_mode_logic dut (.clk_sys, .resetn, .addr, .wdata, .wr_en,
        .rd_en, .rdata_q, .pin_in, .pin_out, .pin_oe_n, .pin_weak_pu_en,
        .pin_very_weak_pu_en, .pin_level_q, .user_config_byte_one,
        .power_on_active, .pin_reset_req_q);
    ppm_ext_circuit ext (.clk_sys, .pin_out, .pin_oe_n, .pin_weak_pu_en,
        .pin_very_weak_pu_en, .ext_en, .ext_val, .pin_in);

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk_rd(input string nm, input logic [7:0] e,
                          input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_pin(input string nm, input logic [7:0] e,
                           input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Read data stands in the cycle after the read strobe
    always @(posedge clk_sys) begin
        if (rd_prev === 1'b1 && exp_q.size() > 0) begin
            chk_rd("rdata_q", exp_q.pop_front(), rdata_q);
        end
        rd_prev <= rd_en;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_sys);
        rd_en <= 1'b0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic do_reset();
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
    endtask
    task automatic chk_reset_state();
        logic [7:0] pu;
        settle(1);
        pu = {7'h00, |(pin_weak_pu_en | pin_very_weak_pu_en)};
        chk_pin("oe_n_all", 8'h01, {7'h00, &pin_oe_n});
        chk_pin("pullups", 8'h00, pu);
        rd(ADDR_MODE_A_BASE, 8'hFF);
        rd(ADDR_MODE_B_BASE, 8'h00);
        rd(ADDR_ANALOG_DIS, 8'h00);
    endtask

    initial begin
        repeat (5000) @(posedge clk_sys);
        n_mismatch++;
        close_out();
    end

    initial begin
        seed = 15435;
        n_mismatch = 0;
        samples_checked = 0;
        resetn = 1'b1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        user_config_byte_one = 8'h40;
        power_on_active = 1'b0;
        ext_en = 26'h300_20FF;
        ext_val = 26'h300_20FF;
        // Reset edge off time zero so every register sees it
        #1 resetn = 1'b0;
        do_reset();
        chk_reset_state();
        settle(20);
        rd(8'h00, 8'hFF);
        wr(8'h00, 8'h00);
        rd(8'h00, 8'hFF);
        rd(8'h03, 8'h03);
        rd(ADDR_USER_CFG, 8'h40);
        rd(8'h20, 8'h00);
        wr(8'h0E, 8'hFF);
        rd(8'h0E, 8'h00);
        // Analog disable masks port 0 reads
        av = 8'($random(seed));
        wr(ADDR_ANALOG_DIS, av);
        settle(3);
        rd(ADDR_ANALOG_DIS, av);
        rd(8'h00, ~(av & ANALOG_USED_MASK));
        pv = 8'($random(seed));
        @(posedge clk_sys);
        ext_val[7:0] <= pv;
        settle(20);
        ep = pv & ~(av & ANALOG_USED_MASK);
        rd(8'h00, ep);
        settle(2);
        chk_pin("lvl_p0", ep, pin_level_q[7:0]);
        // Port 1: reset pin fixed, I2C pins limited
        wr(8'h05, 8'h00);
        wr(8'h09, 8'hFF);
        wr(8'h01, 8'hFF);
        settle(20);
        chk_pin("p1_oe_n", 8'h2C, pin_oe_n[15:8]);
        chk_pin("p1_out", 8'hD3, pin_out[15:8]);
        rd(8'h05, 8'h2C);
        rd(8'h09, 8'hDF);
        wr(8'h01, 8'h00);
        settle(20);
        chk_pin("p1_oe_n0", 8'h20, pin_oe_n[15:8]);
        wr(8'h09, 8'h00);
        settle(20);
        chk_pin("p1_oe_nq", 8'h2C, pin_oe_n[15:8]);
        // Every mode code on port 2 with random latch values
        for (int m = 0; m < 4; m++) begin
            lat = 8'($random(seed));
            wr(8'h02, lat);
            wr(8'h06, {8{m[1]}});
            wr(8'h0A, {8{m[0]}});
            settle(20);
            eo = (m == 2) ? 8'hFF : ((m == 1) ? 8'h00 : lat);
            eu = (m == 1) ? lat : 8'h00;
            ep = (m == 0) ? lat : 8'h00;
            chk_pin("p2_oe_n", eo, pin_oe_n[23:16]);
            chk_pin("p2_out", eu, pin_out[23:16]);
            chk_pin("p2_vweak", ep, pin_very_weak_pu_en[23:16]);
            chk_pin("p2_weak", ep, pin_weak_pu_en[23:16]);
        end
        // Strong pull-up pulse on a rising latch
        wr(8'h06, 8'h00);
        wr(8'h0A, 8'h00);
        wr(8'h02, 8'h00);
        settle(20);
        wr(8'h02, 8'hFF);
        for (int k = 0; k < 4; k++) begin
            if (k == 0) begin
                #1;
            end else begin
                settle(1);
            end
            eu = (k == 1 || k == 2) ? 8'hFF : 8'h00;
            eo = (k == 3) ? 8'hFF : 8'h00;
            chk_pin("pulse_out", eu, pin_out[23:16]);
            chk_pin("pulse_oe_n", eo, pin_oe_n[23:16]);
        end
        wr(8'h02, 8'hFF);
        for (int k = 0; k < 3; k++) begin
            settle(1);
            chk_pin("no_pulse", 8'h00, pin_out[23:16]);
        end
        // Weak pull-up drops while the pin is held low outside
        settle(20);
        chk_pin("weak_on", 8'hFF, pin_weak_pu_en[23:16]);
        @(posedge clk_sys);
        ext_en[16] <= 1'b1;
        ext_val[16] <= 1'b0;
        settle(20);
        chk_pin("weak_off", 8'hFE, pin_weak_pu_en[23:16]);
        chk_pin("vweak_on", 8'hFF, pin_very_weak_pu_en[23:16]);
        @(posedge clk_sys);
        ext_en[16] <= 1'b0;
        settle(20);
        chk_pin("weak_back", 8'hFF, pin_weak_pu_en[23:16]);
        // Short glitch on the reset pin is filtered out
        @(posedge clk_sys);
        ext_val[13] <= 1'b0;
        repeat (4) @(posedge clk_sys);
        ext_val[13] <= 1'b1;
        for (int k = 0; k < 12; k++) begin
            settle(1);
            chk_pin("glitch", 8'h01, {7'h00, pin_level_q[13]});
        end
        @(posedge clk_sys);
        ext_val[13] <= 1'b0;
        settle(20);
        chk_pin("rst_lvl", 8'h00, {7'h00, pin_level_q[13]});
        chk_pin("req_gpi", 8'h00, {7'h00, pin_reset_req_q});
        @(posedge clk_sys);
        user_config_byte_one <= 8'h00;
        settle(3);
        chk_pin("req_rst", 8'h01, {7'h00, pin_reset_req_q});
        @(posedge clk_sys);
        user_config_byte_one <= 8'h40;
        power_on_active <= 1'b1;
        settle(3);
        chk_pin("req_por", 8'h01, {7'h00, pin_reset_req_q});
        @(posedge clk_sys);
        power_on_active <= 1'b0;
        ext_val[13] <= 1'b1;
        settle(3);
        chk_pin("req_off", 8'h00, {7'h00, pin_reset_req_q});
        // Reset in mid-run clears analog disable and modes
        do_reset();
        chk_reset_state();
        settle(20);
        rd(8'h00, pv);
        settle(4);
        close_out();
    end
endmodule
`default_nettype wire
